// ===== src/cimask_pkg.sv
// Purpose: constants and types for the card interface interrupt mask block
// Assumes: 32-bit register port, one clock
// Notes: register offsets are byte addresses of aligned words
package cimask_pkg;

  localparam int CIMASK_DW = 32;
  localparam int CIMASK_AW = 8;
  localparam int CIMASK_CW = 16;

  // --------------------------------------------------------------------------
  // register offsets
  // --------------------------------------------------------------------------
  localparam logic [CIMASK_AW-1:0] CIMASK_OFF_ENABLE_SET = 8'h00;
  localparam logic [CIMASK_AW-1:0] CIMASK_OFF_ENABLE_CLEAR = 8'h04;
  localparam logic [CIMASK_AW-1:0] CIMASK_OFF_ENABLE_STATE = 8'h08;
  localparam logic [CIMASK_AW-1:0] CIMASK_OFF_STATUS = 8'h0C;
  localparam logic [CIMASK_AW-1:0] CIMASK_OFF_EVENT_STATUS = 8'h10;
  localparam logic [CIMASK_AW-1:0] CIMASK_OFF_EVENT_CLEAR = 8'h14;
  localparam logic [CIMASK_AW-1:0] CIMASK_OFF_EVENT_ENABLE = 8'h18;

  // --------------------------------------------------------------------------
  // field positions of the source vector
  // --------------------------------------------------------------------------
  localparam int CIMASK_B_COMMAND_READY = 0;
  localparam int CIMASK_B_RECEIVER_READY = 1;
  localparam int CIMASK_B_TRANSMIT_READY = 2;
  localparam int CIMASK_B_BLOCK_ENDED = 3;
  localparam int CIMASK_B_TRANSFER_IN_PROGRESS = 4;
  localparam int CIMASK_B_CARD_IDLE = 5;
  localparam int CIMASK_B_RECEIVE_BUFFER_END = 6;
  localparam int CIMASK_B_TRANSMIT_BUFFER_END = 7;
  localparam int CIMASK_B_RECEIVE_BUFFERS_FULL = 14;
  localparam int CIMASK_B_TRANSMIT_BUFFERS_EMPTY = 15;
  localparam int CIMASK_B_RESPONSE_INDEX_ERROR = 16;
  localparam int CIMASK_B_DATA_TIMEOUT = 22;
  localparam int CIMASK_B_OVERRUN = 30;
  localparam int CIMASK_B_UNDERRUN = 31;

  // implemented positions: 0-7, 14-15, 16-22, 30-31
  localparam logic [CIMASK_DW-1:0] CIMASK_VALID_BITS = 32'hC07FC0FF;
  localparam logic [CIMASK_DW-1:0] CIMASK_MASK_RESET = 32'h00000000;
  localparam logic [CIMASK_DW-1:0] CIMASK_ZERO_WORD = 32'h00000000;

  // event status bits of the block's own interrupt register
  localparam int CIMASK_EV_W = 2;
  localparam int CIMASK_EV_ENABLE_WRITE = 0;
  localparam int CIMASK_EV_DISABLE_WRITE = 1;
  localparam logic [CIMASK_EV_W-1:0] CIMASK_EV_RESET = 2'h0;

  // --------------------------------------------------------------------------
  // types
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [CIMASK_AW-1:0] addr;
    logic [CIMASK_DW-1:0] wdata;
  } cimask_req_t;

  typedef struct packed {
    logic [CIMASK_DW-1:0] mask;
    logic [CIMASK_EV_W-1:0] ev_status;
    logic [CIMASK_EV_W-1:0] ev_enable;
    logic [CIMASK_DW-1:0] rdata;
    logic irq;
    logic ev_irq;
    logic txbe;
  } cimask_state_t;

endpackage

// ===== src/cimask_top.sv
// Purpose: interrupt enable, disable and mask logic of a card host interface
// Assumes: single 20 MHz clock, register port with read data one cycle later
// Notes: status flags arrive from the rest of the card interface
//
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps

// Summary of operation
// - enable write sets mask bits written one
// - disable write clears mask bits written one
// - mask register reads enabled sources as one
// - bits 0-7 map command through transmit-end
// - bit 14 receive full, bit 15 transmit empty
// - bits 16-22 map response and data errors
// - bit 30 overrun, bit 31 underrun
module cimask_top
  import cimask_pkg::*;
#(
  parameter int COUNT_W = CIMASK_CW
) (
  input wire logic clk_i,                          // 20 MHz clock
  input wire logic rst_i,                          // async reset, high
  input wire logic [CIMASK_AW-1:0] addr_i,         // register byte address
  input wire logic [CIMASK_DW-1:0] wdata_i,        // write data
  input wire logic wr_i,                           // write strobe
  input wire logic rd_i,                           // read strobe
  input wire logic [CIMASK_DW-1:0] status_i,       // status flags of the card interface
  input wire logic [COUNT_W-1:0] transmit_count_i, // transmit count
  input wire logic [COUNT_W-1:0] next_transmit_count_i, // next transmit count
  output logic [CIMASK_DW-1:0] rdata_o,            // read data, cycle after read
  output logic irq_o,                              // card interrupt level
  output logic event_irq_o,                        // register event interrupt level
  output logic transmit_buffers_empty_o            // transmit empty status
);

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  cimask_state_t st;
  cimask_state_t next_st;
  cimask_req_t req;
  logic [CIMASK_DW-1:0] status_full;
  logic txbe_now;

  assign req.wr = wr_i;
  assign req.rd = rd_i;
  assign req.addr = addr_i;
  assign req.wdata = wdata_i;

  function automatic logic hit(input cimask_req_t r, input logic [CIMASK_AW-1:0] off);
    hit = (r.addr == off);
  endfunction

  // both counts zero means nothing left to send
  assign txbe_now = (transmit_count_i == '0) && (next_transmit_count_i == '0);

  // own transmit-empty replaces the incoming flag; unused positions forced low
  always_comb begin
    status_full = status_i & CIMASK_VALID_BITS;
    status_full[CIMASK_B_TRANSMIT_BUFFERS_EMPTY] = st.txbe;
  end

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.txbe = txbe_now;
    next_st.rdata = CIMASK_ZERO_WORD;
    if (req.wr) begin
      if (hit(req, CIMASK_OFF_ENABLE_SET)) begin
        // positions 0-7, 14-15, 16-22, 30-31 only
        next_st.mask = st.mask | (req.wdata & CIMASK_VALID_BITS);
        next_st.ev_status[CIMASK_EV_ENABLE_WRITE] = 1'b1;
      end
      if (hit(req, CIMASK_OFF_ENABLE_CLEAR)) begin
        next_st.mask = st.mask & ~(req.wdata & CIMASK_VALID_BITS);
        next_st.ev_status[CIMASK_EV_DISABLE_WRITE] = 1'b1;
      end
      if (hit(req, CIMASK_OFF_EVENT_CLEAR)) begin
        // a new event in the same cycle wins over the clear
        next_st.ev_status = (st.ev_status & ~req.wdata[CIMASK_EV_W-1:0]) | (next_st.ev_status & ~st.ev_status);
      end
      if (hit(req, CIMASK_OFF_EVENT_ENABLE)) begin
        next_st.ev_enable = req.wdata[CIMASK_EV_W-1:0];
      end
    end
    if (req.rd) begin
      unique case (req.addr)
        CIMASK_OFF_ENABLE_STATE: next_st.rdata = st.mask & CIMASK_VALID_BITS;
        CIMASK_OFF_STATUS: next_st.rdata = status_full;
        CIMASK_OFF_EVENT_STATUS: next_st.rdata = {{(CIMASK_DW-CIMASK_EV_W){1'b0}}, st.ev_status};
        CIMASK_OFF_EVENT_ENABLE: next_st.rdata = {{(CIMASK_DW-CIMASK_EV_W){1'b0}}, st.ev_enable};
        default: next_st.rdata = CIMASK_ZERO_WORD;
      endcase
    end
    next_st.irq = |(status_full & next_st.mask);
    next_st.ev_irq = |(next_st.ev_status & next_st.ev_enable);
  end

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st.mask <= CIMASK_MASK_RESET;
      st.ev_status <= CIMASK_EV_RESET;
      st.ev_enable <= CIMASK_EV_RESET;
      st.rdata <= CIMASK_ZERO_WORD;
      st.irq <= 1'b0;
      st.ev_irq <= 1'b0;
      st.txbe <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign rdata_o = st.rdata;
  assign irq_o = st.irq;
  assign event_irq_o = st.ev_irq;
  assign transmit_buffers_empty_o = st.txbe;

endmodule

// ===== verif/cimask_top_properties.sv
// Purpose: port assertions for the card interrupt mask block
// Assumes: the mask is rebuilt here from register writes
// Notes: bound into every cimask_top
`timescale 1ns/1ps
module cimask_top_chk
  import cimask_pkg::*;
#(parameter int COUNT_W = CIMASK_CW) (
  input wire logic clk_i, // clock
  input wire logic rst_i, // reset
  input wire logic [CIMASK_AW-1:0] addr_i, // address
  input wire logic [CIMASK_DW-1:0] wdata_i, // write data
  input wire logic wr_i, // write
  input wire logic rd_i, // read
  input wire logic [CIMASK_DW-1:0] status_i, // flags
  input wire logic [COUNT_W-1:0] transmit_count_i, // count
  input wire logic [COUNT_W-1:0] next_transmit_count_i, // next count
  input wire logic [CIMASK_DW-1:0] rdata_o, // read data
  input wire logic irq_o, // interrupt
  input wire logic event_irq_o, // event interrupt
  input wire logic transmit_buffers_empty_o // tx empty
);
  logic [CIMASK_DW-1:0] m, sf;
  assign sf = (status_i & 32'hFFFF7FFF) | {16'h0, transmit_buffers_empty_o, 15'h0};
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) m <= CIMASK_MASK_RESET;
    else if (wr_i && addr_i == CIMASK_OFF_ENABLE_SET) m <= m | (wdata_i & CIMASK_VALID_BITS);
    else if (wr_i && addr_i == CIMASK_OFF_ENABLE_CLEAR) m <= m & ~wdata_i;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_set; wr_i && addr_i == CIMASK_OFF_ENABLE_SET ##2 rd_i && addr_i == CIMASK_OFF_ENABLE_STATE; endsequence
  sequence s_clr; wr_i && addr_i == CIMASK_OFF_ENABLE_CLEAR ##2 rd_i && addr_i == CIMASK_OFF_ENABLE_STATE; endsequence
  property p_set; s_set |=> &(rdata_o | ~($past(wdata_i, 3) & CIMASK_VALID_BITS)); endproperty
  a_set: assert property (p_set) else $error("enable write lost");
  property p_clr; s_clr |=> (rdata_o & $past(wdata_i, 3)) == CIMASK_ZERO_WORD; endproperty
  a_clr: assert property (p_clr) else $error("disable write lost");
  property p_state; rd_i && addr_i == CIMASK_OFF_ENABLE_STATE |=> rdata_o == $past(m); endproperty
  a_state: assert property (p_state) else $error("mask readback wrong");
  property p_idle; !rd_i |=> rdata_o == CIMASK_ZERO_WORD; endproperty
  a_idle: assert property (p_idle) else $error("read data without read");
  property p_gap; rd_i && addr_i == CIMASK_OFF_ENABLE_STATE |=> (rdata_o & ~CIMASK_VALID_BITS) == 0; endproperty
  a_gap: assert property (p_gap) else $error("reserved mask bit set");
  property p_unmap; rd_i && addr_i > CIMASK_OFF_EVENT_ENABLE |=> rdata_o == CIMASK_ZERO_WORD; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read nonzero");
  property p_txbe; 1'b1 |=> transmit_buffers_empty_o == ($past(transmit_count_i) == 0 && $past(next_transmit_count_i) == 0); endproperty
  a_txbe: assert property (p_txbe) else $error("tx empty wrong");
  property p_irq; 1'b1 |=> irq_o == |(m & $past(sf)); endproperty
  a_irq: assert property (p_irq) else $error("interrupt level wrong");
endmodule
bind cimask_top cimask_top_chk #(.COUNT_W(COUNT_W)) u_chk (.*);

// ===== verif/testbench.sv
// Purpose: random and corner tests of the card interrupt mask block
// Assumes: 20 MHz clock, read data one cycle after the read strobe
// Notes: event registers at the package offsets
`timescale 1ns/1ps
module testbench;
  import cimask_pkg::*;
  logic clk_i = 0, rst_i = 1, irq_o, event_irq_o, txbe;
  cimask_req_t req = '0;
  logic [CIMASK_DW-1:0] status_i = 32'h0, rdata_o, m, d;
  logic [CIMASK_CW-1:0] tc = 16'h0001, ntc = 16'h0000;
  int err_total = 0, cmp_count = 0, cyc = 0;
  cimask_top u_cimask_top (.clk_i(clk_i), .rst_i(rst_i), .addr_i(req.addr), .wdata_i(req.wdata), .wr_i(req.wr),
    .rd_i(req.rd), .status_i(status_i), .transmit_count_i(tc), .next_transmit_count_i(ntc), .rdata_o(rdata_o),
    .irq_o(irq_o), .event_irq_o(event_irq_o), .transmit_buffers_empty_o(txbe));
  initial forever #25 clk_i = ~clk_i;
  always @(posedge clk_i) if (++cyc == 3000) begin
    err_total++;
    results();
  end
  function automatic logic [31:0] nxt(logic [31:0] mm, logic [31:0] x, logic s); return s ? mm | (x & CIMASK_VALID_BITS) : mm & ~x; endfunction
  task automatic chk(input string n, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin $display("FAIL %s expected %h seen %h", n, e, g); err_total++; end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] x);
    @(posedge clk_i) req <= '{w, !w, a, x};
    @(posedge clk_i) req <= '{1'b0, 1'b0, a, x};
    #1;
  endtask
  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h3C48A819));
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    m = 32'h0;
    bus(0, CIMASK_OFF_ENABLE_STATE, 0); chk("reset_mask", m, rdata_o);
    for (int i = 0; i < 40; i++) begin
      d = $urandom; bus(1, i[0] ? CIMASK_OFF_ENABLE_SET : CIMASK_OFF_ENABLE_CLEAR, d); m = nxt(m, d, i[0]);
      bus(0, CIMASK_OFF_ENABLE_STATE, 0); chk("mask", m, rdata_o);
    end
    $display("mask test done");
    for (int i = 0; i < 32; i++) begin
      bus(1, CIMASK_OFF_ENABLE_CLEAR, 32'hFFFFFFFF); status_i <= 32'h1 << i; tc <= (i == 15) ? 16'h0 : 16'h1;
      bus(1, CIMASK_OFF_ENABLE_SET, 32'h1 << i); @(posedge clk_i) #1;
      chk("irq_map", {31'h0, CIMASK_VALID_BITS[i]}, {31'h0, irq_o});
    end
    $display("map test done");
    for (int i = 0; i < 16; i++) begin
      d = $urandom; @(posedge clk_i) tc <= i[0] ? 16'h0 : d[15:0]; ntc <= i[1] ? 16'h0 : d[31:16];
      repeat (2) @(posedge clk_i); #1 chk("txbe", {31'h0, tc == 0 && ntc == 0}, {31'h0, txbe});
    end
    $display("tx empty test done");
    bus(1, CIMASK_OFF_EVENT_ENABLE, 32'h2); bus(1, CIMASK_OFF_EVENT_CLEAR, 32'h3);
    bus(0, CIMASK_OFF_EVENT_STATUS, 0); chk("ev_clear", 32'h0, rdata_o);
    bus(1, CIMASK_OFF_ENABLE_SET, 0); @(posedge clk_i) #1 chk("ev_masked", 32'h0, {31'h0, event_irq_o});
    bus(1, CIMASK_OFF_ENABLE_CLEAR, 0); @(posedge clk_i) #1 chk("ev_irq", 32'h1, {31'h0, event_irq_o});
    bus(0, CIMASK_OFF_EVENT_STATUS, 0); chk("ev_status", 32'h3, rdata_o);
    bus(1, CIMASK_OFF_EVENT_CLEAR, 32'h3); @(posedge clk_i) #1 chk("ev_drop", 32'h0, {31'h0, event_irq_o});
    bus(0, 8'h40, 0); chk("unmapped", 32'h0, rdata_o);
    bus(0, CIMASK_OFF_EVENT_ENABLE, 0); chk("ev_enable", 32'h2, rdata_o);
    bus(0, CIMASK_OFF_STATUS, 0); chk("status", 32'h80008000, rdata_o);
    $display("event test done");
    results();
  end
endmodule
